// [bench/sms_card_core_tb.sv]
// self-checking bench for the card command interpreter
`default_nettype none
module sms_card_core_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] PIN = 16'h1234;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic link_lost_i = 1'b0;
  wire logic cyc, stb, we, ack, s_open, p_blk;
  wire logic [7:0] adr;
  wire logic [3:0] sel;
  wire logic [31:0] wdat, rdat;
  int bad_count = 0;
  int tests_run = 0;
  int cyc_n = 0;
  logic [31:0] rng = 32'h5a404c82;
  logic [63:0] exp_q[$];
  logic [63:0] m_e;
  logic gr = 1'b0, bl = 1'b0, op = 1'b0, iv = 1'b0;
  always #50 clk_i = ~clk_i;
  sms_card_core sms_card_core_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .link_lost_i(link_lost_i), .session_open_o(s_open), .pin_blocked_o(p_blk));
  sms_term_model sms_term_model_inst (.clk_i(clk_i), .wb_cyc_o(cyc), .wb_stb_o(stb), .wb_we_o(we),
    .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(wdat), .wb_dat_i(rdat), .wb_ack_i(ack));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : xs
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    exp_q.push_back({m, e});
    sms_term_model_inst.xfer(1'b0, a, 32'h0, q);
  endtask : rd
  // directory flag left out: it depends on what is selected
  task automatic sts(input logic [15:0] s, input logic [31:0] m = 32'hfff7ffff);
    rd(sms_pkg::REG_STATUS, m, {11'h0, iv, 1'b0, op, bl, gr, s} & m);
  endtask : sts
  task automatic cmd(input sms_pkg::sms_op_t o, input logic [15:0] a);
    sms_term_model_inst.cmd(o, a);
  endtask : cmd
  task automatic conclude();
    $display("counts: %0d compared, %0d mismatched", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : conclude
  // ----------------------------------------------------------------
  // monitor and timeout
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (ack === 1'b1 && we === 1'b0) begin
      if (exp_q.size() == 0) begin
        chk("unexpected read ack", 32'h0, 32'h1);
      end else begin
        m_e = exp_q.pop_front();
        chk("read data", m_e[31:0], rdat & m_e[63:32]);
      end
    end
  end
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      bad_count++;
      conclude();
    end
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] r;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    sts(sms_pkg::SW_RESET, 32'hffffffff);
    sms_term_model_inst.wr(8'h18, xs());
    rd(8'h18, 32'hffffffff, 32'h0);
    chk("pin_blocked_o", 32'h0, {31'h0, p_blk});
    $display("test reset done");
    cmd(sms_pkg::OP_OPEN, 16'h0);
    op = 1'b1;
    cmd(sms_pkg::OP_SELECT, sms_pkg::DIR_APP_ID);
    sts(sms_pkg::SW_OK);
    rd(sms_pkg::REG_STATUS, 32'h00080000, 32'h00080000);
    chk("session_open_o", 32'h1, {31'h0, s_open});
    cmd(sms_pkg::OP_STATUS, 16'h0);
    rd(sms_pkg::REG_RDATA, 32'hffffffff, {16'h0, sms_pkg::DIR_APP_ID});
    sms_term_model_inst.wr(sms_pkg::REG_ACCESS, 32'h0);
    cmd(sms_pkg::OP_SELECT, {sms_pkg::EF_ID_HI, 8'h00});
    cmd(sms_pkg::OP_READ, 16'h0003);
    sts(sms_pkg::SW_DENIED);
    rd(sms_pkg::REG_RDATA, 32'hffffffff, 32'h0);
    sms_term_model_inst.wr(sms_pkg::REG_WDATA, 32'ha5);
    cmd(sms_pkg::OP_UPDATE, 16'h0003);
    sts(sms_pkg::SW_DENIED);
    cmd(sms_pkg::OP_INVAL, 16'h0);
    sts(sms_pkg::SW_DENIED);
    cmd(sms_pkg::OP_VERIFY, PIN);
    gr = 1'b1;
    sts(sms_pkg::SW_OK);
    $display("test access refusal done");
    for (int i = 0; i < 4; i++) begin
      r = xs();
      if (i == 0) r[3:0] = 4'hf;
      sms_term_model_inst.wr(sms_pkg::REG_WDATA, {24'h0, r[15:8]});
      cmd(sms_pkg::OP_UPDATE, {12'h0, r[3:0]});
      sts(sms_pkg::SW_OK);
      cmd(sms_pkg::OP_READ, {12'h0, r[3:0]});
      rd(sms_pkg::REG_RDATA, 32'hffffffff, {24'h0, r[15:8]});
    end
    cmd(sms_pkg::OP_READ, 16'h0010);
    sts(sms_pkg::SW_BAD_OFF);
    cmd(sms_pkg::OP_INVAL, 16'h0);
    iv = 1'b1;
    sts(sms_pkg::SW_OK);
    cmd(sms_pkg::OP_READ, 16'h0000);
    sts(sms_pkg::SW_INVALID);
    $display("test file access done");
    iv = 1'b0;
    cmd(sms_pkg::OP_SELECT, sms_pkg::DIR_MF_ID);
    cmd(sms_pkg::OP_STATUS, 16'h0);
    rd(sms_pkg::REG_RDATA, 32'hffffffff, {16'h0, sms_pkg::DIR_MF_ID});
    cmd(sms_pkg::OP_READ, 16'h0000);
    sts(sms_pkg::SW_NO_EF);
    cmd(sms_pkg::OP_SELECT, {sms_pkg::EF_ID_HI, 8'h00});
    sts(sms_pkg::SW_NOT_FOUND);
    rd(sms_pkg::REG_CMD, 32'hffffffff, {29'h0, sms_pkg::OP_SELECT});
    rd(sms_pkg::REG_ARG, 32'hffffffff, {16'h0, sms_pkg::EF_ID_HI, 8'h00});
    cmd(sms_pkg::OP_SELECT, sms_pkg::DIR_APP_ID);
    $display("test directory change done");
    cmd(sms_pkg::OP_SELECT, {sms_pkg::EF_ID_HI, 8'h01});
    iv = 1'b0;
    sms_term_model_inst.wr(sms_pkg::REG_WDATA, 32'h3c);
    cmd(sms_pkg::OP_UPDATE, 16'h0002);
    sms_term_model_inst.wr(sms_pkg::REG_ACCESS, 32'h2);
    @(posedge clk_i);
    link_lost_i <= 1'b1;
    @(posedge clk_i);
    link_lost_i <= 1'b0;
    op = 1'b0;
    gr = 1'b0;
    repeat (2) @(posedge clk_i);
    chk("session_open_o", 32'h0, {31'h0, s_open});
    sts(sms_pkg::SW_OK, 32'h00170000);
    cmd(sms_pkg::OP_OPEN, 16'h0);
    cmd(sms_pkg::OP_SELECT, sms_pkg::DIR_APP_ID);
    cmd(sms_pkg::OP_SELECT, {sms_pkg::EF_ID_HI, 8'h01});
    sms_term_model_inst.wr(sms_pkg::REG_WDATA, 32'hc3);
    cmd(sms_pkg::OP_UPDATE, 16'h0002);
    sts(sms_pkg::SW_DENIED, 32'h0000ffff);
    cmd(sms_pkg::OP_READ, 16'h0002);
    rd(sms_pkg::REG_RDATA, 32'hffffffff, 32'h3c);
    $display("test link loss done");
    cmd(sms_pkg::OP_VERIFY, PIN);
    sms_term_model_inst.wr(sms_pkg::REG_WDATA, 32'h5a);
    cmd(sms_pkg::OP_UPDATE, 16'h0002);
    rd(sms_pkg::REG_STATUS, 32'h0001ffff, {16'h1, sms_pkg::SW_OK});
    for (int i = 0; i < 3; i++) begin
      cmd(sms_pkg::OP_VERIFY, ~PIN);
      if (i < 2) sts(sms_pkg::SW_DENIED, 32'h0002ffff);
    end
    rd(sms_pkg::REG_STATUS, 32'h00030000, 32'h00020000);
    chk("pin_blocked_o", 32'h1, {31'h0, p_blk});
    cmd(sms_pkg::OP_CLOSE, 16'h0);
    sms_term_model_inst.init(PIN);
    rd(sms_pkg::REG_STATUS, 32'h0003ffff, {16'h2, sms_pkg::SW_BLOCKED});
    chk("pin_blocked_o", 32'h1, {31'h0, p_blk});
    chk("session_open_o", 32'h1, {31'h0, s_open});
    $display("test pin blocking done");
    repeat (3) @(posedge clk_i);
    chk("terminal late", 32'h0, {31'h0, sms_term_model_inst.late});
    conclude();
  end
endmodule : sms_card_core_tb
`default_nettype wire

// [bench/sms_term_model.sv]
// terminal side model: wishbone master that issues every card command
`default_nettype none
module sms_term_model #(
  parameter int unsigned SEC_CYCLES = 10
) (
  // clock
  input wire logic clk_i,
  // wishbone master
  output var logic wb_cyc_o,
  output var logic wb_stb_o,
  output var logic wb_we_o,
  output var logic [7:0] wb_adr_o,
  output var logic [3:0] wb_sel_o,
  output var logic [31:0] wb_dat_o,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_i
);
  timeunit 1ns;
  timeprecision 1ns;
  // terminal timers count clock cycles; a second is scaled down so a run stays short
  int unsigned idle_n = 0;
  int unsigned wait_n = 0;
  logic late = 1'b0;
  // inactivity restarts at every answer; a slow answer or a long silence sets late
  always @(posedge clk_i) begin
    if (wb_ack_i === 1'b1) begin
      idle_n <= 0;
    end else begin
      idle_n <= idle_n + 1;
    end
    if (wb_cyc_o && wb_ack_i !== 1'b1) begin
      wait_n <= wait_n + 1;
    end else begin
      wait_n <= 0;
    end
    if (idle_n >= 30 * SEC_CYCLES || wait_n >= 5 * SEC_CYCLES) begin
      late <= 1'b1;
    end
  end
  initial begin
    wb_cyc_o = 1'b0;
    wb_stb_o = 1'b0;
    wb_we_o = 1'b0;
    wb_adr_o = 8'h00;
    wb_sel_o = 4'hf;
    wb_dat_o = 32'h0;
  end
  // ----------------------------------------------------------------
  // bus cycle
  // ----------------------------------------------------------------
  // the card never speaks first; released address and data lines are scrambled, not held
  task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o <= we;
    wb_adr_o <= a;
    wb_dat_o <= d;
    do @(posedge clk_i); while (wb_ack_i !== 1'b1);
    q = wb_dat_i;
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    wb_adr_o <= ~a;
    wb_dat_o <= ~d;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr
  task automatic cmd(input sms_pkg::sms_op_t op, input logic [15:0] arg);
    wr(sms_pkg::REG_ARG, {16'h0, arg});
    wr(sms_pkg::REG_CMD, {29'h0, op});
  endtask : cmd
  // ----------------------------------------------------------------
  // session start
  // ----------------------------------------------------------------
  // open, app directory by its id, then pin one
  task automatic init(input logic [15:0] pin);
    cmd(sms_pkg::OP_OPEN, 16'h0);
    cmd(sms_pkg::OP_SELECT, sms_pkg::DIR_APP_ID);
    cmd(sms_pkg::OP_VERIFY, pin);
  endtask : init
endmodule : sms_term_model
`default_nettype wire

// [hw/sms_card_core.sv]
// subscriber card command interpreter with wishbone register access
//
// Chosen here: the register offsets and register access over Wishbone.
`default_nettype none
module sms_card_core #(
  parameter int NUM_FILES = 4,
  parameter int FILE_BYTES = 16,
  parameter logic [15:0] PIN_VALUE = 16'h1234
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // link and state
  input wire logic link_lost_i,
  output logic session_open_o,
  output logic pin_blocked_o
);
  localparam int FW = (NUM_FILES > 1) ? $clog2(NUM_FILES) : 1;
  localparam int OW = (FILE_BYTES > 1) ? $clog2(FILE_BYTES) : 1;
  localparam logic [7:0] NF8 = 8'(NUM_FILES);
  localparam logic [7:0] FB8 = 8'(FILE_BYTES);

  sms_pin_if pin ();

  logic ack_q;
  logic [2:0] last_op_q;
  logic [15:0] arg_q;
  logic [7:0] wdata_q;
  logic [15:0] rdata_q;
  logic [15:0] sw_q;
  logic [15:0] sw_d;
  logic [NUM_FILES-1:0] free_read_q;
  logic [NUM_FILES-1:0] inval_q;
  logic [FW-1:0] ef_q;
  logic ef_valid_q;
  logic dir_app_q;
  logic session_q;
  logic [7:0] mem [NUM_FILES][FILE_BYTES];
  logic req;
  logic wr;
  logic cmd_go;
  sms_pkg::sms_op_t op;
  logic [OW-1:0] off;
  logic ef_usable;
  logic rd_ok;
  logic upd_ok;
  logic inv_ok;

  // ---------------------------------------------------------------
  // bus slave
  // ---------------------------------------------------------------
  // one wait state: every request is answered on the second edge
  assign req = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr = req && wb_we_i;
  assign cmd_go = wr && (wb_adr_i == sms_pkg::REG_CMD) && wb_sel_i[0];
  assign op = sms_pkg::sms_op_t'(wb_dat_i[2:0]);
  assign off = arg_q[OW-1:0];
  assign wb_ack_o = ack_q;
  assign session_open_o = session_q;
  assign pin_blocked_o = pin.blocked;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (req && !wb_we_i) begin
      if (wb_adr_i == sms_pkg::REG_CMD) begin
        wb_dat_o <= {29'h0, last_op_q};
      end else if (wb_adr_i == sms_pkg::REG_ARG) begin
        wb_dat_o <= {16'h0, arg_q};
      end else if (wb_adr_i == sms_pkg::REG_WDATA) begin
        wb_dat_o <= {24'h0, wdata_q};
      end else if (wb_adr_i == sms_pkg::REG_RDATA) begin
        wb_dat_o <= {16'h0, rdata_q};
      end else if (wb_adr_i == sms_pkg::REG_STATUS) begin
        wb_dat_o <= {11'h0, inval_q[ef_q] && ef_valid_q, dir_app_q, session_q, pin.blocked, pin.granted, sw_q};
      end else if (wb_adr_i == sms_pkg::REG_ACCESS) begin
        wb_dat_o <= 32'(free_read_q);
      end else begin
        wb_dat_o <= 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      arg_q <= 16'h0000;
      wdata_q <= 8'h00;
      free_read_q <= '0;
    end else if (wr) begin
      if (wb_adr_i == sms_pkg::REG_ARG) begin
        if (wb_sel_i[0]) arg_q[7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1]) arg_q[15:8] <= wb_dat_i[15:8];
      end else if (wb_adr_i == sms_pkg::REG_WDATA && wb_sel_i[0]) begin
        wdata_q <= wb_dat_i[7:0];
      end else if (wb_adr_i == sms_pkg::REG_ACCESS && wb_sel_i[0]) begin
        free_read_q <= wb_dat_i[NUM_FILES-1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // access decisions
  // ---------------------------------------------------------------
  assign ef_usable = ef_valid_q && !inval_q[ef_q] && (arg_q[7:0] < FB8);
  assign rd_ok = ef_usable && (pin.granted || free_read_q[ef_q]);
  assign upd_ok = ef_usable && pin.granted;
  assign inv_ok = ef_valid_q && pin.granted;

  assign pin.verify = cmd_go && (op == sms_pkg::OP_VERIFY);
  assign pin.presented = arg_q;
  assign pin.session_end = link_lost_i || (cmd_go && op == sms_pkg::OP_CLOSE);

  always_comb begin
    sw_d = sms_pkg::SW_OK;
    case (op)
      sms_pkg::OP_SELECT: begin
        if (arg_q != sms_pkg::DIR_APP_ID && arg_q != sms_pkg::DIR_MF_ID &&
            !(dir_app_q && arg_q[15:8] == sms_pkg::EF_ID_HI && arg_q[7:0] < NF8)) sw_d = sms_pkg::SW_NOT_FOUND;
      end
      sms_pkg::OP_READ, sms_pkg::OP_UPDATE, sms_pkg::OP_INVAL: begin
        if (!ef_valid_q) sw_d = sms_pkg::SW_NO_EF;
        else if (op != sms_pkg::OP_INVAL && inval_q[ef_q]) sw_d = sms_pkg::SW_INVALID;
        else if (op != sms_pkg::OP_INVAL && arg_q[7:0] >= FB8) sw_d = sms_pkg::SW_BAD_OFF;
        else if (op == sms_pkg::OP_READ && !rd_ok) sw_d = sms_pkg::SW_DENIED;
        else if (op == sms_pkg::OP_UPDATE && !upd_ok) sw_d = sms_pkg::SW_DENIED;
        else if (op == sms_pkg::OP_INVAL && !inv_ok) sw_d = sms_pkg::SW_DENIED;
      end
      sms_pkg::OP_VERIFY: begin
        if (pin.blocked) sw_d = sms_pkg::SW_BLOCKED;
        else if (!pin.match) sw_d = sms_pkg::SW_DENIED;
      end
      default: begin
        sw_d = sms_pkg::SW_OK;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // command execution
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sw_q <= sms_pkg::SW_RESET;
      last_op_q <= 3'h0;
      rdata_q <= 16'h0000;
    end else if (cmd_go) begin
      sw_q <= sw_d;
      last_op_q <= op;
      if (op == sms_pkg::OP_READ) begin
        rdata_q <= rd_ok ? {8'h00, mem[ef_q][off]} : 16'h0000;
      end else if (op == sms_pkg::OP_STATUS) begin
        rdata_q <= dir_app_q ? sms_pkg::DIR_APP_ID : sms_pkg::DIR_MF_ID;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dir_app_q <= 1'b0;
      ef_valid_q <= 1'b0;
      ef_q <= '0;
    end else if (cmd_go && op == sms_pkg::OP_SELECT) begin
      if (arg_q == sms_pkg::DIR_APP_ID) begin
        dir_app_q <= 1'b1;
        ef_valid_q <= 1'b0;
      end else if (arg_q == sms_pkg::DIR_MF_ID) begin
        dir_app_q <= 1'b0;
        ef_valid_q <= 1'b0;
      end else if (sw_d == sms_pkg::SW_OK) begin
        ef_q <= arg_q[FW-1:0];
        ef_valid_q <= 1'b1;
      end
    end
  end

  // file contents clear at reset, so a refused update never compares unknown bytes;
  // a real card would hold them in nonvolatile store
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int f = 0; f < NUM_FILES; f++) begin
        for (int b = 0; b < FILE_BYTES; b++) begin
          mem[f][b] <= 8'h00;
        end
      end
    end else if (cmd_go && op == sms_pkg::OP_UPDATE && upd_ok) begin
      mem[ef_q][off] <= wdata_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      inval_q <= '0;
    end else if (cmd_go && op == sms_pkg::OP_INVAL && inv_ok) begin
      inval_q[ef_q] <= 1'b1;
    end
  end

  // link loss outranks an open in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      session_q <= 1'b0;
    end else if (pin.session_end) begin
      session_q <= 1'b0;
    end else if (cmd_go && op == sms_pkg::OP_OPEN) begin
      session_q <= 1'b1;
    end
  end

  sms_pin_check #(
    .PIN_VALUE(PIN_VALUE)
  ) u_pin (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin(pin)
  );

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  bus_answer_a: assert property (req |=> wb_ack_o ##1 !wb_ack_o || req)
    else $error("request not answered in one cycle");
  no_spurious_ack_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  app_select_a: assert property (cmd_go && op == sms_pkg::OP_SELECT && arg_q == sms_pkg::DIR_APP_ID
    |=> dir_app_q && !ef_valid_q && sw_q == sms_pkg::SW_OK)
    else $error("application directory not selected");
  read_denied_a: assert property (cmd_go && op == sms_pkg::OP_READ && ef_usable && !pin.granted
    && !free_read_q[ef_q] |=> sw_q == sms_pkg::SW_DENIED && rdata_q == 16'h0000)
    else $error("read returned data without access");
  read_data_a: assert property (cmd_go && op == sms_pkg::OP_READ && rd_ok
    |=> rdata_q[7:0] == $past(mem[ef_q][off]) && sw_q == sms_pkg::SW_OK)
    else $error("read data wrong");
  update_store_a: assert property (cmd_go && op == sms_pkg::OP_UPDATE && upd_ok
    |=> mem[$past(ef_q)][$past(off)] == $past(wdata_q))
    else $error("update not stored");
  update_denied_a: assert property (cmd_go && op == sms_pkg::OP_UPDATE && ef_usable && !pin.granted
    |=> sw_q == sms_pkg::SW_DENIED && mem[$past(ef_q)][$past(off)] == $past(mem[ef_q][off]))
    else $error("denied update changed data");
  inval_guard_a: assert property (cmd_go && op == sms_pkg::OP_INVAL && !pin.granted |=> $stable(inval_q))
    else $error("invalidated without access");
  link_loss_a: assert property (link_lost_i |=> !session_q ##1 !session_q || $past(cmd_go))
    else $error("session open after link loss");

  cv_read_c: cover property (cmd_go && op == sms_pkg::OP_READ && rd_ok);
  cv_update_c: cover property (cmd_go && op == sms_pkg::OP_UPDATE && upd_ok);
  cv_session_c: cover property (session_q ##[1:20] !session_q);
endmodule : sms_card_core
`default_nettype wire

// [hw/sms_pin_check.sv]
// pin one checker: try counter, block and access right
`default_nettype none
module sms_pin_check #(
  parameter logic [15:0] PIN_VALUE = 16'h1234
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // core side
  sms_pin_if.pin pin
);
  logic [1:0] tries_q;
  logic granted_q;

  assign pin.match = (pin.presented == PIN_VALUE);
  assign pin.blocked = (tries_q == 2'h0);
  assign pin.granted = granted_q;

  // only reset or a correct pin restores tries, so a count survives session close
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tries_q <= sms_pkg::PIN_TRIES;
    end else if (pin.verify && !pin.blocked) begin
      tries_q <= pin.match ? sms_pkg::PIN_TRIES : tries_q - 2'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      granted_q <= 1'b0;
    end else if (pin.session_end) begin
      granted_q <= 1'b0;
    end else if (pin.verify) begin
      granted_q <= pin.match && !pin.blocked;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  third_wrong_blocks_a: assert property (
    pin.verify && !pin.match && tries_q == 2'h1 |=> pin.blocked && !granted_q)
    else $error("pin not blocked after third wrong try");
  blocked_no_right_a: assert property (pin.blocked |-> !granted_q)
    else $error("access right kept while pin blocked");
  good_pin_grants_a: assert property (
    pin.verify && pin.match && !pin.blocked && !pin.session_end |=> granted_q && tries_q == sms_pkg::PIN_TRIES)
    else $error("correct pin not granted");
  cv_blocked_c: cover property (pin.verify ##1 pin.blocked);
endmodule : sms_pin_check
`default_nettype wire

// [hw/sms_pin_if.sv]
// link between the command core and the pin checker
`default_nettype none
interface sms_pin_if;
  logic verify;
  logic [15:0] presented;
  logic session_end;
  logic match;
  logic granted;
  logic blocked;
  modport core (output verify, output presented, output session_end,
                input match, input granted, input blocked);
  modport pin (input verify, input presented, input session_end,
               output match, output granted, output blocked);
endinterface : sms_pin_if
`default_nettype wire

// [hw/sms_pkg.sv]
// shared constants for the subscriber card command interpreter
`default_nettype none
package sms_pkg;
  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ARG = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_RDATA = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_ACCESS = 8'h14;
  // ---------------------------------------------------------------
  // command opcodes
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_CLOSE = 3'h0,
    OP_SELECT = 3'h1,
    OP_READ = 3'h2,
    OP_UPDATE = 3'h3,
    OP_INVAL = 3'h4,
    OP_VERIFY = 3'h5,
    OP_STATUS = 3'h6,
    OP_OPEN = 3'h7
  } sms_op_t;
  // ---------------------------------------------------------------
  // file identifiers and status words
  // ---------------------------------------------------------------
  localparam logic [15:0] DIR_APP_ID = 16'h7f90;
  localparam logic [15:0] DIR_MF_ID = 16'h3f00;
  localparam logic [7:0] EF_ID_HI = 8'h6f;
  localparam logic [15:0] SW_OK = 16'h9000;
  localparam logic [15:0] SW_NO_EF = 16'h9400;
  localparam logic [15:0] SW_NOT_FOUND = 16'h6a82;
  localparam logic [15:0] SW_DENIED = 16'h9804;
  localparam logic [15:0] SW_BLOCKED = 16'h9840;
  localparam logic [15:0] SW_INVALID = 16'h9808;
  localparam logic [15:0] SW_BAD_OFF = 16'h6b00;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] SW_RESET = 16'h0000;
  localparam logic [1:0] PIN_TRIES = 2'h3;
endpackage : sms_pkg
`default_nettype wire
